//--- src/roc_pkg.sv
// Package: constants and types for the relay output conditioner
// ---------------------------------------------
// ---------------------------------------------
package roc_pkg;

    localparam int SRC_W = 5;
    localparam int TIME_W = 14;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 15;
    localparam logic [TIME_W-1:0] TIME_MAX = 14'h270F;
    localparam logic [TIME_W-1:0] DELAY_RST = 14'h0000;
    localparam logic [TIME_W-1:0] HOLD_RST = 14'h0000;
    localparam logic POL_RST = 1'b0;

    // Source codes; low ones are general conditions routed in on cond_bus
    typedef enum logic [SRC_W-1:0] {
        SRC_NONE = 5'h00,
        SRC_FAULT_FREE = 5'h01,
        SRC_GEN_FIRST = 5'h02,
        SRC_GEN_LAST = 5'h17,
        SRC_BRAKE = 5'h18,
        SRC_LINE = 5'h19,
        SRC_OUTPUT = 5'h1A,
        SRC_END_REEL = 5'h1B,
        SRC_WOBBLE_SYNC = 5'h1C,
        SRC_DC_PRECHARGE = 5'h1D
    } roc_src_t;

    // Per-relay settings
    typedef struct packed {
        logic [SRC_W-1:0] source;
        logic [TIME_W-1:0] on_delay;
        logic [TIME_W-1:0] hold_time;
        logic active_low_select;
    } roc_cfg_t;

    // Application function conditions
    typedef struct packed {
        logic brake_contactor_source;
        logic line_contactor_source;
        logic output_contactor_source;
        logic end_reel;
        logic wobble_sync;
        logic dc_precharge_source;
    } roc_app_t;

    function automatic logic [TIME_W-1:0] roc_clip(input logic [TIME_W-1:0] v);
        roc_clip = (v > TIME_MAX) ? TIME_MAX : v;
    endfunction

endpackage

//--- src/roc_relay.sv
// One relay channel: source pick, forced settings, timers, polarity
`timescale 1ns/1ps
`default_nettype none
module roc_relay
    import roc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic card_present,
    input wire roc_cfg_t cfg,
    input wire logic [31:0] cond_bus,
    input wire roc_app_t app,
    output logic relay_out,
    output logic [TIME_W-1:0] eff_delay,
    output logic [TIME_W-1:0] eff_hold,
    output logic pol_locked
);
    // ---------------------------------------------
    // Source selection and forced settings
    // ---------------------------------------------
    wire logic [SRC_W-1:0] s = cfg.source;
    wire logic is_ff = (s == SRC_FAULT_FREE);
    wire logic is_line = (s == SRC_LINE);
    wire logic is_brake = (s == SRC_BRAKE);
    wire logic is_dc = (s == SRC_DC_PRECHARGE);
    wire logic is_occ = (s == SRC_OUTPUT);
    wire logic force_delay0 = is_ff | is_brake | is_dc | is_line | is_occ;
    wire logic force_hold0 = is_ff | is_line;
    assign pol_locked = is_ff | is_brake | is_dc | is_line;
    assign eff_delay = force_delay0 ? '0 : roc_clip(cfg.on_delay);
    assign eff_hold = force_hold0 ? '0 : roc_clip(cfg.hold_time);
    wire logic neg = cfg.active_low_select & ~pol_locked;

    logic cond;
    always_comb
    begin
        unique case (s)
            SRC_BRAKE: cond = app.brake_contactor_source;
            SRC_LINE: cond = app.line_contactor_source;
            SRC_OUTPUT: cond = app.output_contactor_source;
            SRC_END_REEL: cond = app.end_reel;
            SRC_WOBBLE_SYNC: cond = app.wobble_sync;
            SRC_DC_PRECHARGE: cond = app.dc_precharge_source;
            SRC_NONE: cond = 1'b0;
            default: cond = (s >= SRC_GEN_FIRST && s <= SRC_GEN_LAST) || is_ff ? cond_bus[s] : 1'b0;
        endcase
    end

    // ---------------------------------------------
    // Delay and hold timing
    // ---------------------------------------------
    // Reversal before expiry restarts; a pulse shorter than its delay or hold time less one tick never reaches the relay
    logic state_r;
    logic [TIME_W-1:0] cnt_r;
    wire logic live = cond & card_present;
    wire logic diff = live ^ state_r;
    wire logic [TIME_W-1:0] limit = live ? eff_delay : eff_hold;
    wire logic expire = diff & ((cnt_r >= limit) | (tick & (cnt_r + 14'h0001 >= limit)));

    always_ff @(posedge clk)
    begin
        if (!rstn || !card_present)
        begin
            state_r <= 1'b0;
            cnt_r <= '0;
        end
        else if (!diff || expire)
        begin
            state_r <= expire ? live : state_r;
            cnt_r <= '0;
        end
        else if (tick)
            cnt_r <= cnt_r + 14'h0001;
    end

    logic out_r;
    always_ff @(posedge clk)
    begin
        if (!rstn)
            out_r <= 1'b0;
        else
            out_r <= card_present & (state_r ^ neg);
    end
    assign relay_out = out_r;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    property p_nocard;
        @(posedge clk) disable iff (!rstn) !card_present |=> !relay_out;
    endproperty
    a_nocard: assert property (p_nocard) else $error("relay on without card");
    property p_delay0;
        @(posedge clk) disable iff (!rstn) force_delay0 && diff && live |=> state_r;
    endproperty
    a_delay0: assert property (p_delay0) else $error("delay not forced");
    property p_hold0;
        @(posedge clk) disable iff (!rstn) force_hold0 && diff && !live |=> !state_r;
    endproperty
    a_hold0: assert property (p_hold0) else $error("hold not forced");
    property p_lock;
        @(posedge clk) disable iff (!rstn) pol_locked && card_present |=> relay_out == $past(state_r);
    endproperty
    a_lock: assert property (p_lock) else $error("polarity not positive");
    property p_occ;
        @(posedge clk) disable iff (!rstn) is_occ && diff && live |=> state_r;
    endproperty
    a_occ: assert property (p_occ) else $error("output contactor delay");
    property p_none;
        @(posedge clk) disable iff (!rstn) s == SRC_NONE |-> !cond;
    endproperty
    a_none: assert property (p_none) else $error("unassigned active");
    property p_wait_on;
        @(posedge clk) disable iff (!rstn) diff && live && cnt_r < limit && !tick |=> !state_r;
    endproperty
    a_wait_on: assert property (p_wait_on) else $error("on change early");
    property p_wait_off;
        @(posedge clk) disable iff (!rstn) card_present && diff && !live && cnt_r < limit && !tick |=> state_r;
    endproperty
    a_wait_off: assert property (p_wait_off) else $error("off change early");
    property p_restart;
        @(posedge clk) disable iff (!rstn) card_present && !diff |=> cnt_r == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");
endmodule // roc_relay
`default_nettype wire

//--- src/roc_top.sv
// Top: tick generator, card detect sync, relays 3 and 4
`timescale 1ns/1ps
`default_nettype none
module roc_top
    import roc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic card3_detect,
    input wire logic card4_detect,
    input wire logic [31:0] cond_bus,
    input wire roc_app_t app,
    input wire roc_cfg_t relay3_cfg,
    input wire roc_cfg_t relay4_cfg,
    output logic relay3_out,
    output logic relay4_out,
    output logic relay3_available,
    output logic relay4_available,
    output logic [TIME_W-1:0] relay3_on_delay,
    output logic [TIME_W-1:0] relay3_hold_time,
    output logic relay3_polarity,
    output logic [TIME_W-1:0] relay4_on_delay,
    output logic [TIME_W-1:0] relay4_hold_time,
    output logic relay4_polarity
);
    // ---------------------------------------------
    // Millisecond tick
    // ---------------------------------------------
    logic [TICK_W-1:0] div_r;
    wire logic tick = (div_r == TICK_W'(TICK_CYC - 1));
    always_ff @(posedge clk)
    begin
        if (!rstn)
            div_r <= '0;
        else
            div_r <= tick ? '0 : div_r + 15'h0001;
    end

    // ---------------------------------------------
    // Card detect synchronisers
    // ---------------------------------------------
    logic [1:0] m_r;
    logic [1:0] s_r;
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            m_r <= '0;
            s_r <= '0;
        end
        else
        begin
            m_r <= {card4_detect, card3_detect};
            s_r <= m_r;
        end
    end
    assign relay3_available = s_r[0];
    assign relay4_available = s_r[1];

    logic lk3;
    logic lk4;
    roc_relay u_r3 (.clk(clk), .rstn(rstn), .tick(tick), .card_present(s_r[0]), .cfg(relay3_cfg),
        .cond_bus(cond_bus), .app(app), .relay_out(relay3_out), .eff_delay(relay3_on_delay),
        .eff_hold(relay3_hold_time), .pol_locked(lk3));
    roc_relay u_r4 (.clk(clk), .rstn(rstn), .tick(tick), .card_present(s_r[1]), .cfg(relay4_cfg),
        .cond_bus(cond_bus), .app(app), .relay_out(relay4_out), .eff_delay(relay4_on_delay),
        .eff_hold(relay4_hold_time), .pol_locked(lk4));
    assign relay3_polarity = relay3_cfg.active_low_select & ~lk3;
    assign relay4_polarity = relay4_cfg.active_low_select & ~lk4;
endmodule // roc_top
`default_nettype wire

//--- bench/roc_load.sv
// Behavioural contactor coil on the far side of one relay
`timescale 1ns/1ps
`default_nettype none
module roc_load
(
    input wire logic clk,
    input wire logic drive,
    output logic coil
);
    // One cycle pick-up; a real coil is far slower
    always_ff @(posedge clk)
    begin
        coil <= drive;
    end
endmodule // roc_load
`default_nettype wire

//--- bench/tb.sv
// Self-checking testbench for the relay output conditioner
`timescale 1ns/1ps
`default_nettype none
module tb;
    import roc_pkg::*;
    logic clk, rstn, card3_detect, card4_detect, r3, r4, av3, av4, p3, p4, coil3, coil4;
    logic [TIME_W-1:0] d3, h3, d4, h4;
    logic [31:0] cond_bus;
    roc_app_t app;
    roc_cfg_t cfg3, cfg4;
    int failures, check_count;
    roc_top i_dut (.clk(clk), .rstn(rstn), .card3_detect(card3_detect), .card4_detect(card4_detect),
        .cond_bus(cond_bus), .app(app), .relay3_cfg(cfg3), .relay4_cfg(cfg4), .relay3_out(r3),
        .relay4_out(r4), .relay3_available(av3), .relay4_available(av4), .relay3_on_delay(d3),
        .relay3_hold_time(h3), .relay3_polarity(p3), .relay4_on_delay(d4), .relay4_hold_time(h4),
        .relay4_polarity(p4));
    roc_load i_load3 (.clk(clk), .drive(r3), .coil(coil3));
    roc_load i_load4 (.clk(clk), .drive(r4), .coil(coil4));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string name, input logic [TIME_W-1:0] seen, input logic [TIME_W-1:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("out3", r3, 0);
        chk("delay3", d3, 14'h0000);
        chk("hold3", h3, 14'h0000);
        chk("pol3", p3, 0);
        cyc(4);
        chk("avail3", av3, 1);
        chk("avail4", av4, 1);
        $display("done t_reset");
    endtask
    task automatic t_card;
        card3_detect = 1'b0;
        card4_detect = 1'b0;
        cfg3 = '{5'h02, 14'h0000, 14'h0000, 1'b1};
        cfg4 = '{5'h00, 14'h0000, 14'h0000, 1'b1};
        cyc(4);
        chk("avail3", av3, 0);
        chk("out3", r3, 0);
        chk("avail4", av4, 0);
        chk("out4", r4, 0);
        card3_detect = 1'b1;
        card4_detect = 1'b1;
        cyc(5);
        chk("out3 neg idle", r3, 1);
        chk("coil3", coil3, 1);
        chk("pol3 neg", p3, 1);
        chk("avail4 back", av4, 1);
        chk("out4 neg idle", r4, 1);
        chk("coil4", coil4, 1);
        cond_bus = 32'h0000_0004;
        cyc(3);
        chk("out3 neg true", r3, 0);
        cfg3 = '{SRC_BRAKE, 14'h0000, 14'h0000, 1'b1};
        app.brake_contactor_source = 1'b1;
        cyc(3);
        chk("out3 brake", r3, 1);
        chk("pol3 locked", p3, 0);
        app.brake_contactor_source = 1'b0;
        cyc(3);
        chk("out3 brake off", r3, 0);
        $display("done t_card");
    endtask
    task automatic t_forced;
        roc_src_t s [7] = '{SRC_FAULT_FREE, SRC_BRAKE, SRC_LINE, SRC_OUTPUT, SRC_DC_PRECHARGE, SRC_END_REEL,
            SRC_WOBBLE_SYNC};
        logic zd, zh, lk;
        foreach (s[i])
        begin
            cfg4 = '{s[i], 14'h3FFF, 14'h2710, 1'b1};
            zd = s[i] inside {SRC_FAULT_FREE, SRC_BRAKE, SRC_LINE, SRC_OUTPUT, SRC_DC_PRECHARGE};
            zh = s[i] inside {SRC_FAULT_FREE, SRC_LINE};
            lk = s[i] inside {SRC_FAULT_FREE, SRC_BRAKE, SRC_LINE, SRC_DC_PRECHARGE};
            cyc(1);
            chk("delay4", d4, zd ? 14'h0000 : TIME_MAX);
            chk("hold4", h4, zh ? 14'h0000 : TIME_MAX);
            chk("pol4", p4, !lk);
        end
        $display("done t_forced");
    endtask
    task automatic t_app;
        roc_src_t s [7] = '{SRC_FAULT_FREE, SRC_BRAKE, SRC_LINE, SRC_OUTPUT, SRC_END_REEL, SRC_WOBBLE_SYNC,
            SRC_DC_PRECHARGE};
        roc_app_t a [7] = '{6'h00, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
        foreach (s[i])
        begin
            cfg4 = '{s[i], 14'h0000, 14'h0000, 1'b0};
            app = a[i];
            cond_bus = (i == 0) ? 32'h0000_0002 : 32'h0000_0000;
            cyc(3);
            chk("out4 source on", r4, 1);
            app = '0;
            cond_bus = 32'h0000_0000;
            cyc(3);
            chk("out4 source off", r4, 0);
        end
        $display("done t_app");
    endtask
    task automatic t_timing;
        int i;
        cfg3 = '{5'h03, 14'h0002, 14'h0000, 1'b0};
        cfg4 = '{5'h04, 14'h0000, 14'h0002, 1'b0};
        cond_bus = 32'h0000_0010;
        cyc(5);
        chk("out4 on", r4, 1);
        cond_bus = 32'h0000_0008;
        cyc(19000);
        chk("out3 withheld", r3, 0);
        chk("out4 held", r4, 1);
        for (i = 0; i < 25000 && r3 !== 1'b1; i++)
            cyc(1);
        chk("out3 late", r3, 1);
        chk("out3 window", (19000 + i >= 20002) && (19000 + i <= 40001), 1);
        chk("out4 late", r4, 0);
        cond_bus = 32'h0000_0000;
        cyc(5);
        cond_bus = 32'h0000_0008;
        cyc(15000);
        cond_bus = 32'h0000_0000;
        cyc(26000);
        chk("out3 cancelled", r3, 0);
        $display("done t_timing");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #(100000 * 50);
        failures++;
        wrap_up();
    end
    initial
    begin
        rstn = 1'b0;
        card3_detect = 1'b1;
        card4_detect = 1'b1;
        cond_bus = 32'h0000_0000;
        app = '0;
        cfg3 = '0;
        cfg4 = '0;
        cyc(4);
        rstn = 1'b1;
        cyc(1);
        t_reset();
        t_card();
        t_forced();
        t_app();
        t_timing();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
